// File: logic/interrupt_flag_priority_regs.v
// Interrupt flag, edge select and priority registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "irq_flag_regs_defines.vh"

// Behaviour
// RQ1: Flags set on events regardless of enables.
// RQ2: Edge select bits 6..3: 1 rising, 0 falling.
// RQ3: Bit 7 disables all pull-ups, else latch decides.
// RQ4: Priority bits: 1 high, 0 low.
// RQ5: External enables at bits 5,4,3.
// RQ6: External flags at bits 2,1,0, set on selected edge.
// RQ7: Request registers hold the peripheral flags.
// RQ8: Receive flags read-only, high while buffer holds data.
// RQ9: Transmit flags read-only, high while buffer empty.
// RQ10: Oscillator fail flag, cleared by software.
// RQ11: Capture/compare flags, unused in PWM.
// RQ12: Sync serial flags set on completion.
// RQ13: Bus collision flags at bits 4 and 3.
// RQ14: Voltage detect flag at bit 2.
// RQ15: Timer overflow and match flags.
// RQ16: Timer gate event flags.
// RQ17: Software clears a flag before enabling it.
// RQ18: Converter done flag.
// RQ19: Parallel port flag on external access.
// RQ20: Real-time clock flag bit 0, charge time bit 3.
// RQ21: Priority levels act only when enabled.
// RQ22: Without levels all requests use the high vector.
// RQ23: High vector 0008h, low vector 0018h.
// RQ24: Hardware set beats same-cycle software clear.
module interrupt_flag_priority_regs (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address and data
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    output wire [1:0]  s_axi_bresp,
    // AXI4-Lite read
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [5:0]  s_axi_araddr,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    // External interrupt pins 1 to 3 (asynchronous)
    input  wire [2:0]  ext_pin,
    // Port B pull-ups
    input  wire [7:0]  port_b_latch,
    output reg  [7:0]  port_b_pullup_en,
    // Peripheral event pulses, one cycle each
    input  wire        parallel_port_evt,
    input  wire        adc_done_evt,
    input  wire        sync_serial1_evt,
    input  wire        timer1_gate_evt,
    input  wire        timer2_match_evt,
    input  wire        timer1_ovf_evt,
    input  wire        osc_fail_evt,
    input  wire        sync_serial2_evt,
    input  wire        bus_collision2_evt,
    input  wire        bus_collision1_evt,
    input  wire        voltage_detect_evt,
    input  wire        timer3_ovf_evt,
    input  wire        timer3_gate_evt,
    input  wire        timer5_gate_evt,
    input  wire        charge_time_evt,
    input  wire        rtc_evt,
    // Capture/compare channels: mode 00 capture, 01 compare, 1x PWM
    input  wire [1:0]  capcomp1_mode,
    input  wire        capcomp1_capture_evt,
    input  wire        capcomp1_compare_evt,
    input  wire [1:0]  capcomp2_mode,
    input  wire        capcomp2_capture_evt,
    input  wire        capcomp2_compare_evt,
    // Serial buffer status levels
    input  wire        serial1_rx_full,
    input  wire        serial1_tx_empty,
    input  wire        serial2_rx_full,
    input  wire        serial2_tx_empty,
    // Flag, enable and priority state toward the vectoring logic
    output wire [7:0]  edge_pullup_priority_ctrl,
    output wire [7:0]  external_irq_ctrl,
    output wire [7:0]  peripheral_flags_one,
    output wire [7:0]  peripheral_flags_two,
    output wire [7:0]  peripheral_flags_three,
    output wire        priority_levels_enable,
    output wire        global_irq_enable,
    output wire        timer0_ovf_priority,
    output wire        port_change_priority,
    output wire        ext0_edge_select,
    // External interrupt request toward the core
    output reg         ext_irq_req,
    output reg  [15:0] ext_irq_vector
);

    // ************************************************************
    // Register file
    // ************************************************************
    reg  [7:0]  edge_ctrl_r;
    reg  [7:0]  ext_ctrl_r;
    reg  [7:0]  pflags_one_r;
    reg  [7:0]  pflags_two_r;
    reg  [7:0]  pflags_three_r;
    reg  [7:0]  global_ctrl_r;

    // Address decode, shared by the write and read paths
    function mapped;
        input [5:0] addr;
        begin
            mapped = (addr == `OFS_EDGE_CTRL) || (addr == `OFS_EXT_CTRL) ||
                     (addr == `OFS_PFLAGS_ONE) || (addr == `OFS_PFLAGS_TWO) ||
                     (addr == `OFS_PFLAGS_THREE) || (addr == `OFS_GLOBAL_CTRL);
        end
    endfunction

    // Capture/compare flag source selected by channel mode
    function capcomp_set;
        input [1:0] mode;
        input       capture_evt;
        input       compare_evt;
        begin
            capcomp_set = (mode == 2'b00) ? capture_evt :
                          (mode == 2'b01) ? compare_evt : 1'b0;
        end
    endfunction

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    reg         aw_got_r;
    reg         w_got_r;
    reg  [5:0]  awaddr_r;
    reg  [7:0]  wbyte_r;
    reg         wstrb0_r;
    reg         bvalid_r;
    reg  [1:0]  bresp_r;

    wire        aw_now  = s_axi_awvalid & s_axi_awready;
    wire        w_now   = s_axi_wvalid & s_axi_wready;
    wire        have_aw = aw_got_r | aw_now;
    wire        have_w  = w_got_r | w_now;
    wire        do_wr   = have_aw & have_w;
    wire [5:0]  wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
    wire [7:0]  wr_byte = w_got_r ? wbyte_r : s_axi_wdata[7:0];
    wire        wr_lane = w_got_r ? wstrb0_r : s_axi_wstrb[0];
    // Only byte lane 0 carries register bits; upper lanes are ignored
    wire        wr_en   = do_wr & wr_lane;

    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready  = ~w_got_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 6'h00;
            wbyte_r  <= 8'h00;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else begin
            if (do_wr) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (aw_now) begin
                    aw_got_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr;
                end
                if (w_now) begin
                    w_got_r  <= 1'b1;
                    wbyte_r  <= s_axi_wdata[7:0];
                    wstrb0_r <= s_axi_wstrb[0];
                end
                if (bvalid_r && s_axi_bready) begin
                    bvalid_r <= 1'b0;
                end
            end
        end
    end

    wire wr_edge   = wr_en && (wr_addr == `OFS_EDGE_CTRL);
    wire wr_ext    = wr_en && (wr_addr == `OFS_EXT_CTRL);
    wire wr_one    = wr_en && (wr_addr == `OFS_PFLAGS_ONE);
    wire wr_two    = wr_en && (wr_addr == `OFS_PFLAGS_TWO);
    wire wr_three  = wr_en && (wr_addr == `OFS_PFLAGS_THREE);
    wire wr_global = wr_en && (wr_addr == `OFS_GLOBAL_CTRL);

    // ************************************************************
    // External input synchronisers and edge detectors
    // ************************************************************
    reg  [2:0]  ext_s1_r;
    reg  [2:0]  ext_s2_r;
    reg  [2:0]  ext_s3_r;
    reg  [2:0]  ext_lvl_r;
    wire [2:0]  ext_evt;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext
            // A change counts only once stages two and three agree
            wire stable = (ext_s2_r[gi] == ext_s3_r[gi]);
            wire rising = edge_ctrl_r[`BIT_EXT1_EDGE - gi];
            assign ext_evt[gi] = stable && (ext_s3_r[gi] != ext_lvl_r[gi]) &&
                                 (ext_s3_r[gi] == rising); // RQ2
            always @(posedge aclk) begin
                if (!aresetn) begin
                    ext_s1_r[gi]  <= 1'b0;
                    ext_s2_r[gi]  <= 1'b0;
                    ext_s3_r[gi]  <= 1'b0;
                    ext_lvl_r[gi] <= 1'b0;
                end else begin
                    ext_s1_r[gi] <= ext_pin[gi];
                    ext_s2_r[gi] <= ext_s1_r[gi];
                    ext_s3_r[gi] <= ext_s2_r[gi];
                    if (stable) begin
                        ext_lvl_r[gi] <= ext_s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Flag set sources
    // ************************************************************
    wire [7:0] set_one = {parallel_port_evt,               // RQ19
                          adc_done_evt,                    // RQ18
                          2'b00,
                          sync_serial1_evt,                // RQ12
                          timer1_gate_evt,                 // RQ16
                          timer2_match_evt,                // RQ15
                          timer1_ovf_evt};                 // RQ15
    wire [7:0] set_two = {osc_fail_evt,                    // RQ10
                          1'b0,
                          sync_serial2_evt,                // RQ12
                          bus_collision2_evt,              // RQ13
                          bus_collision1_evt,              // RQ13
                          voltage_detect_evt,              // RQ14
                          timer3_ovf_evt,                  // RQ15
                          timer3_gate_evt};                // RQ16
    wire [7:0] set_three = {timer5_gate_evt,               // RQ16
                            3'b000,
                            charge_time_evt,               // RQ20
                            capcomp_set(capcomp2_mode, capcomp2_capture_evt,
                                        capcomp2_compare_evt), // RQ11
                            capcomp_set(capcomp1_mode, capcomp1_capture_evt,
                                        capcomp1_compare_evt), // RQ11
                            rtc_evt};                      // RQ20

    // Set wins over a same-cycle software write; flags ignore enables
    wire [7:0] one_nxt   = (set_one | (wr_one ? wr_byte : pflags_one_r)) &
                           `WMASK_PFLAGS_ONE; // RQ1 RQ24
    wire [7:0] two_nxt   = (set_two | (wr_two ? wr_byte : pflags_two_r)) &
                           `WMASK_PFLAGS_TWO; // RQ1 RQ24
    wire [7:0] three_nxt = (set_three | (wr_three ? wr_byte : pflags_three_r)) &
                           `WMASK_PFLAGS_THREE; // RQ1 RQ24
    wire [2:0] ext_flag_nxt = ext_evt |
                              (wr_ext ? wr_byte[2:0] : ext_ctrl_r[2:0]); // RQ6 RQ24

    always @(posedge aclk) begin
        if (!aresetn) begin
            edge_ctrl_r    <= `RST_EDGE_CTRL;
            ext_ctrl_r     <= `RST_EXT_CTRL;
            pflags_one_r   <= `RST_PFLAGS;
            pflags_two_r   <= `RST_PFLAGS;
            pflags_three_r <= `RST_PFLAGS;
            global_ctrl_r  <= `RST_GLOBAL_CTRL;
        end else begin
            if (wr_edge) begin
                edge_ctrl_r <= wr_byte;
            end
            if (wr_ext) begin
                ext_ctrl_r[7:3] <= wr_byte[7:3]; // RQ5
            end
            ext_ctrl_r[2:0] <= ext_flag_nxt; // RQ6
            pflags_one_r    <= one_nxt; // RQ7
            pflags_two_r    <= two_nxt; // RQ7
            pflags_three_r  <= three_nxt; // RQ7
            if (wr_global) begin
                global_ctrl_r <= {6'b000000, wr_byte[1:0]};
            end
        end
    end

    // Serial flags mirror buffer state and ignore writes
    assign peripheral_flags_one   = {pflags_one_r[7:6], serial1_rx_full,
                                     serial1_tx_empty, pflags_one_r[3:0]}; // RQ8 RQ9
    assign peripheral_flags_two   = pflags_two_r;
    assign peripheral_flags_three = {pflags_three_r[7], 1'b0, serial2_rx_full,
                                     serial2_tx_empty, pflags_three_r[3:0]}; // RQ8 RQ9
    assign edge_pullup_priority_ctrl = edge_ctrl_r;
    assign external_irq_ctrl         = ext_ctrl_r;
    assign priority_levels_enable    = global_ctrl_r[`BIT_PRIO_LEVELS];
    assign global_irq_enable         = global_ctrl_r[`BIT_GLOBAL_EN];
    assign timer0_ovf_priority       = edge_ctrl_r[`BIT_T0_PRIO]; // RQ4
    assign port_change_priority      = edge_ctrl_r[`BIT_PCHG_PRIO]; // RQ4
    assign ext0_edge_select          = edge_ctrl_r[`BIT_EXT0_EDGE]; // RQ2

    // ************************************************************
    // Pull-ups and external request vectoring
    // ************************************************************
    wire [2:0] ext_prio = {edge_ctrl_r[`BIT_EXT3_PRIO],
                           ext_ctrl_r[`BIT_EXT2_PRIO],
                           ext_ctrl_r[`BIT_EXT1_PRIO]}; // RQ4
    wire [2:0] ext_act  = ext_ctrl_r[2:0] & ext_ctrl_r[`BIT_EXT1_EN+2:`BIT_EXT1_EN]; // RQ5
    // Without priority levels every source counts as high
    wire [2:0] ext_hi   = ext_prio | {3{~priority_levels_enable}}; // RQ21 RQ22

    always @(posedge aclk) begin
        if (!aresetn) begin
            port_b_pullup_en <= 8'h00;
            ext_irq_req      <= 1'b0;
            ext_irq_vector   <= `VEC_HIGH;
        end else begin
            port_b_pullup_en <= edge_ctrl_r[`BIT_PULLUP_DIS] ? 8'h00 : port_b_latch; // RQ3
            ext_irq_req      <= global_irq_enable && (|ext_act);
            ext_irq_vector   <= (|(ext_act & ext_hi)) ? `VEC_HIGH : `VEC_LOW; // RQ23
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    reg         rvalid_r;
    reg  [7:0]  rbyte_r;
    reg  [1:0]  rresp_r;
    reg  [7:0]  rd_mux;

    always @* begin
        case (s_axi_araddr)
            `OFS_EDGE_CTRL:    rd_mux = edge_ctrl_r;
            `OFS_EXT_CTRL:     rd_mux = ext_ctrl_r;
            `OFS_PFLAGS_ONE:   rd_mux = peripheral_flags_one;
            `OFS_PFLAGS_TWO:   rd_mux = peripheral_flags_two;
            `OFS_PFLAGS_THREE: rd_mux = peripheral_flags_three;
            `OFS_GLOBAL_CTRL:  rd_mux = global_ctrl_r;
            default:           rd_mux = 8'h00;
        endcase
    end

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = {24'h000000, rbyte_r};
    assign s_axi_rresp   = rresp_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rbyte_r  <= 8'h00;
            rresp_r  <= `RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rbyte_r  <= rd_mux;
            rresp_r  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule // interrupt_flag_priority_regs

// File: logic/irq_flag_regs_defines.vh
// Register map, field positions and reset values of the interrupt flag block
`ifndef IRQ_FLAG_REGS_DEFINES_VH
`define IRQ_FLAG_REGS_DEFINES_VH

// Byte offsets on the register bus
`define OFS_EDGE_CTRL     6'h00
`define OFS_EXT_CTRL      6'h04
`define OFS_PFLAGS_ONE    6'h08
`define OFS_PFLAGS_TWO    6'h0c
`define OFS_PFLAGS_THREE  6'h10
`define OFS_GLOBAL_CTRL   6'h14

// Reset values
`define RST_EDGE_CTRL     8'hff
`define RST_EXT_CTRL      8'hc0
`define RST_PFLAGS        8'h00
`define RST_GLOBAL_CTRL   8'h00

// Edge, pull-up and priority control fields
`define BIT_PULLUP_DIS    7
`define BIT_EXT0_EDGE     6
`define BIT_EXT1_EDGE     5
`define BIT_T0_PRIO       2
`define BIT_EXT3_PRIO     1
`define BIT_PCHG_PRIO     0

// External input control fields
`define BIT_EXT2_PRIO     7
`define BIT_EXT1_PRIO     6
`define BIT_EXT1_EN       3
`define BIT_EXT1_FLAG     0

// Global control fields
`define BIT_PRIO_LEVELS   0
`define BIT_GLOBAL_EN     1

// Software-writable bits of the flag registers
`define WMASK_PFLAGS_ONE   8'hcf
`define WMASK_PFLAGS_TWO   8'hbf
`define WMASK_PFLAGS_THREE 8'h8f

// Vector addresses
`define VEC_HIGH          16'h0008
`define VEC_LOW           16'h0018

// Bus responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// File: test/event_source_model.sv
// Peripheral event sources issuing one-cycle pulses on request
`timescale 1ns/1ps
module event_source_model (
    // Clock and request
    input  wire       aclk,
    input  wire       go,
    input  wire [4:0] sel,
    // Event pulses
    output wire parallel_port_evt, adc_done_evt, sync_serial1_evt, timer1_gate_evt,
    output wire timer2_match_evt, timer1_ovf_evt, osc_fail_evt, sync_serial2_evt,
    output wire bus_collision2_evt, bus_collision1_evt, voltage_detect_evt, timer3_ovf_evt,
    output wire timer3_gate_evt, timer5_gate_evt, charge_time_evt, rtc_evt,
    output wire capcomp1_capture_evt, capcomp1_compare_evt,
    output wire capcomp2_capture_evt, capcomp2_compare_evt
);
    reg [19:0] p_r;
    // Sources share the block clock, so a pulse lasts exactly one cycle
    always @(posedge aclk) begin
        p_r <= go ? (20'h00001 << sel) : 20'h00000;
    end
    assign {capcomp2_compare_evt, capcomp2_capture_evt, capcomp1_compare_evt,
            capcomp1_capture_evt, rtc_evt, charge_time_evt, timer5_gate_evt,
            timer3_gate_evt, timer3_ovf_evt, voltage_detect_evt, bus_collision1_evt,
            bus_collision2_evt, sync_serial2_evt, osc_fail_evt, timer1_ovf_evt,
            timer2_match_evt, timer1_gate_evt, sync_serial1_evt, adc_done_evt,
            parallel_port_evt} = p_r;
endmodule // event_source_model

// File: test/irq_flag_sva.sv
// Concurrent checks on the interrupt flag block ports
`timescale 1ns/1ps
module irq_flag_sva (
    // Clock, reset and bus
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Block state
    input wire [7:0]  port_b_latch,
    input wire [7:0]  port_b_pullup_en,
    input wire        adc_done_evt,
    input wire [7:0]  edge_pullup_priority_ctrl,
    input wire [7:0]  external_irq_ctrl,
    input wire [7:0]  peripheral_flags_one,
    input wire        priority_levels_enable,
    input wire        global_irq_enable,
    input wire        ext_irq_req,
    input wire [15:0] ext_irq_vector
);
    wire [7:0] x = external_irq_ctrl;
    wire       hi = (x[0] & x[3] & x[6]) | (x[1] & x[4] & x[7])
                  | (x[2] & x[5] & edge_pullup_priority_ctrl[1]);
    wire       act = |(x[2:0] & x[5:3]);
    wire       want = global_irq_enable & act;
    wire       to_hi = hi | (act & !priority_levels_enable);
    wire       to_lo = priority_levels_enable & !hi;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_write_resp:
        assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
            |=> s_axi_bvalid) else $error("write response late");
    chk_read_resp:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
            else $error("read response late");
    chk_read_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
            else $error("read data dropped");
    chk_pullup_ctrl:
        assert property (port_b_pullup_en ==
            ($past(edge_pullup_priority_ctrl[7]) ? 8'h00 : $past(port_b_latch)))
            else $error("pull-up enables wrong");
    chk_flag_adc:
        assert property (adc_done_evt |=> peripheral_flags_one[6])
            else $error("converter flag not set");
    chk_irq_req:
        assert property (ext_irq_req == $past(want)) else $error("request wrong");
    chk_vec_high:
        assert property ($past(to_hi) |-> ext_irq_vector == 16'h0008)
            else $error("high vector wrong");
    chk_vec_low:
        assert property ($past(to_lo) |-> ext_irq_vector == 16'h0018)
            else $error("low vector wrong");
endmodule // irq_flag_sva

bind interrupt_flag_priority_regs irq_flag_sva chk (.*);

// File: test/test_interrupt_flag_priority_regs.sv
// Self-checking bench of the interrupt flag block
`timescale 1ns/1ps
module test_interrupt_flag_priority_regs;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, go;
    logic        serial1_rx_full, serial1_tx_empty, serial2_rx_full, serial2_tx_empty;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  ext_pin;
    logic [7:0]  port_b_latch;
    logic [1:0]  capcomp1_mode, capcomp2_mode, resp;
    logic [4:0]  sel;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [7:0]  port_b_pullup_en, edge_pullup_priority_ctrl, external_irq_ctrl;
    wire  [7:0]  peripheral_flags_one, peripheral_flags_two, peripheral_flags_three;
    wire         priority_levels_enable, global_irq_enable, timer0_ovf_priority;
    wire         port_change_priority, ext0_edge_select, ext_irq_req;
    wire  [15:0] ext_irq_vector;
    wire         parallel_port_evt, adc_done_evt, sync_serial1_evt, timer1_gate_evt;
    wire         timer2_match_evt, timer1_ovf_evt, osc_fail_evt, sync_serial2_evt;
    wire         bus_collision2_evt, bus_collision1_evt, voltage_detect_evt, timer3_ovf_evt;
    wire         timer3_gate_evt, timer5_gate_evt, charge_time_evt, rtc_evt;
    wire         capcomp1_capture_evt, capcomp1_compare_evt;
    wire         capcomp2_capture_evt, capcomp2_compare_evt;
    int          bad_count, n_tests;
    // Register index and bit per event, event 15 first
    localparam logic [127:0] EV_MAP = 128'h20232710111213141517000102030607;
    localparam logic [47:0]  RST_MAP = 48'h00000000c0ff;

    interrupt_flag_priority_regs dut (.*);
    event_source_model src (.*);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // Bus cycles and event pulses
    // ****************************************
    // A set ev_i lands that event on the write edge
    task wr(input logic [5:0] a, input logic [7:0] d, input int ev_i = -1);
        if (ev_i >= 0) begin
            go <= 1'b1;
            sel <= ev_i[4:0];
            @(posedge aclk);
            go <= 1'b0;
        end
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        cmp(resp, (a > 6'h14) ? 2'b10 : 2'b00);
    endtask

    task rd(input logic [5:0] a, input logic [7:0] e);
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        s_axi_araddr <= a;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        resp = s_axi_rresp;
        cmp(s_axi_rdata, {24'h000000, e});
    endtask

    task pulse(input int i);
        go <= 1'b1;
        sel <= i[4:0];
        @(posedge aclk);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        int i;
        for (i = 0; i < 6; i++) rd(6'(4 * i), RST_MAP[8 * i +: 8]);
        rd(6'h18, 8'h00);
        cmp(resp, 2'b10);
        wr(6'h18, 8'hff);
        cmp(resp, 2'b10);
    endtask

    task t_ctrl;
        port_b_latch <= 8'ha5;
        wr(6'h00, 8'h5a);
        rd(6'h00, 8'h5a);
        cmp(port_b_pullup_en, 8'ha5);
        cmp({ext0_edge_select, timer0_ovf_priority, port_change_priority}, 3'b100);
        wr(6'h00, 8'hff);
        repeat (2) @(posedge aclk);
        cmp(port_b_pullup_en, 8'h00);
    endtask

    task t_flags;
        int i;
        logic [7:0] m;
        logic [5:0] a;
        for (i = 0; i < 16; i++) begin
            m = EV_MAP[8 * i +: 8];
            a = 6'h08 + {m[5:4], 2'b00};
            pulse(i);
            cmp({peripheral_flags_three, peripheral_flags_two, peripheral_flags_one},
                32'h1 << {m[5:4], m[2:0]});
            rd(a, 8'h01 << m[2:0]);
            wr(a, 8'h00);
            rd(a, 8'h00);
        end
        wr(6'h08, 8'hff);
        rd(6'h08, 8'hcf);
        wr(6'h0c, 8'hff);
        rd(6'h0c, 8'hbf);
        wr(6'h10, 8'hff);
        rd(6'h10, 8'h8f);
        wr(6'h08, 8'h00, 1);
        rd(6'h08, 8'h40);
        wr(6'h08, 8'h00);
        wr(6'h0c, 8'h00);
        wr(6'h10, 8'h00);
    endtask

    task t_serial;
        {serial1_rx_full, serial1_tx_empty, serial2_rx_full, serial2_tx_empty} <= 4'b1001;
        wr(6'h08, 8'h00);
        rd(6'h08, 8'h20);
        rd(6'h10, 8'h10);
        {serial1_rx_full, serial1_tx_empty, serial2_rx_full, serial2_tx_empty} <= 4'b0110;
        wr(6'h10, 8'h00);
        rd(6'h08, 8'h10);
        rd(6'h10, 8'h20);
        {serial1_rx_full, serial1_tx_empty, serial2_rx_full, serial2_tx_empty} <= 4'b0000;
    endtask

    task t_capcomp;
        int m, c, k;
        for (m = 0; m < 3; m++) begin
            capcomp1_mode <= m[1:0];
            capcomp2_mode <= m[1:0];
            for (c = 0; c < 2; c++) for (k = 0; k < 2; k++) begin
                pulse(16 + 2 * c + k);
                rd(6'h10, (m == k) ? (8'h02 << c) : 8'h00);
                wr(6'h10, 8'h00);
            end
        end
    endtask

    task t_ext;
        wr(6'h00, 8'hef);
        wr(6'h04, 8'hc0);
        ext_pin <= 3'b111;
        repeat (8) @(posedge aclk);
        rd(6'h04, 8'hc5);
        ext_pin <= 3'b000;
        repeat (8) @(posedge aclk);
        rd(6'h04, 8'hc7);
        wr(6'h04, 8'hc0);
        rd(6'h04, 8'hc0);
    endtask

    task t_irq;
        wr(6'h04, 8'h08);
        wr(6'h14, 8'h02);
        ext_pin <= 3'b001;
        repeat (8) @(posedge aclk);
        cmp({ext_irq_req, ext_irq_vector}, 17'h10008);
        wr(6'h14, 8'h03);
        repeat (2) @(posedge aclk);
        cmp({ext_irq_req, ext_irq_vector}, 17'h10018);
        wr(6'h04, 8'h49);
        repeat (2) @(posedge aclk);
        cmp({ext_irq_req, ext_irq_vector}, 17'h10008);
        wr(6'h04, 8'h41);
        repeat (2) @(posedge aclk);
        cmp({ext_irq_req, ext_irq_vector}, 17'h00018);
        wr(6'h14, 8'h00);
        ext_pin <= 3'b000;
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {serial1_rx_full, serial1_tx_empty, serial2_rx_full, serial2_tx_empty, go} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_pin, port_b_latch, sel} = '0;
        {capcomp1_mode, capcomp2_mode} = '0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_ctrl;
        t_flags;
        t_serial;
        t_capcomp;
        t_ext;
        t_irq;
        test_done;
    end

    // Run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        test_done;
    end
endmodule // test_interrupt_flag_priority_regs
